// *** rtl/cmx_top.sv ***
// comparator mux control register and pin routing
// assumes comparator result levels arrive synchronous to clk; analog muxes sit outside
//
// Added by the designer: strobed register access.
`include "cmx_params.svh"
module cmx_top (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset,
	// register port
	input  wire logic [`CMX_ADDR_W-1:0]   addr,
	input  wire logic [7:0]               wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output logic      [7:0]               rdata,
	// comparator results from the analog side
	input  wire logic                     first_result_in,
	input  wire logic                     second_result_in,
	// analog mux selects
	output cmx_pkg::cmx_src_t             c1_inv_sel,
	output cmx_pkg::cmx_src_t             c1_non_sel,
	output cmx_pkg::cmx_src_t             c2_inv_sel,
	output cmx_pkg::cmx_src_t             c2_non_sel,
	output logic                          comparators_on,
	// pin three result output
	output logic                          analog_pin_three_out,
	output logic                          analog_pin_three_oe,
	// open-drain pin four: only ever pulls low
	output logic                          open_drain_timer_pin_out,
	output logic                          open_drain_timer_pin_oe
);
	import cmx_pkg::*;

	logic      [3:0] ctrl;
	logic            first_result_bit;
	logic            second_result_bit;
	logic            pin3_is_output;
	logic            pin4_drives_result;
	logic            hit;
	cmx_mode_t       mode;
	logic            switch_bit;

	assign hit = (addr == `CMX_CTRL_ADDR);
	// mode and switch views of the control bits, shared by the decode and the checks
	assign mode       = ctrl[`CMX_MODE_HI:`CMX_MODE_LO];
	assign switch_bit = ctrl[`CMX_SWITCH_BIT];

	// ==========================================
	// writable control bits, cleared at reset
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl <= `CMX_CTRL_RESET;
		end else if (wr && hit) begin
			ctrl <= wdata[`CMX_SWITCH_BIT:`CMX_MODE_LO];
		end
	end

	// result bits follow the comparators; writes to them are dropped
	always_ff @(posedge clk) begin
		if (reset) begin
			first_result_bit  <= 1'b0;
			second_result_bit <= 1'b0;
		end else begin
			first_result_bit  <= first_result_in & comparators_on;
			second_result_bit <= second_result_in & comparators_on;
		end
	end

	// ==========================================
	// read data one cycle after strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (rd && hit) begin
			rdata <= {second_result_bit, first_result_bit, 2'b00, ctrl};
		end else begin
			rdata <= 8'h00;
		end
	end

	cmx_route u_route (
		.switch_bit         (switch_bit),
		.mode               (mode),
		.c1_inv_sel         (c1_inv_sel),
		.c1_non_sel         (c1_non_sel),
		.c2_inv_sel         (c2_inv_sel),
		.c2_non_sel         (c2_non_sel),
		.pin3_is_output     (pin3_is_output),
		.pin4_drives_result (pin4_drives_result),
		.comparators_on     (comparators_on)
	);

	// ==========================================
	// result pins, registered so they never glitch
	always_ff @(posedge clk) begin
		if (reset) begin
			analog_pin_three_out     <= 1'b0;
			analog_pin_three_oe      <= 1'b0;
			open_drain_timer_pin_out <= 1'b0;
			open_drain_timer_pin_oe  <= 1'b0;
		end else begin
			analog_pin_three_out     <= first_result_bit;
			analog_pin_three_oe      <= pin3_is_output;
			open_drain_timer_pin_out <= 1'b0;
			// open drain: in mode 110 drive low when result low, else release for timer input
			open_drain_timer_pin_oe  <= pin4_drives_result & ~second_result_bit;
		end
	end

	// ==========================================
	// checks
	property p_reset_clear;
		@(posedge clk) reset |=> (ctrl == `CMX_CTRL_RESET);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("ctrl not cleared");

	property p_write;
		@(posedge clk) disable iff (reset) (wr && hit) |=> (ctrl == $past(wdata[`CMX_SWITCH_BIT:`CMX_MODE_LO]));
	endproperty
	a_write: assert property (p_write) else $error("write lost");

	property p_read_zero;
		@(posedge clk) disable iff (reset) (rd && hit) |=> (rdata[`CMX_FIRST_BIT-1:`CMX_SWITCH_BIT+1] == 2'b00);
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("unused bits set");

	property p_read_ctrl;
		@(posedge clk) disable iff (reset) (rd && hit && !wr) |=> (rdata[3:0] == $past(ctrl));
	endproperty
	a_read_ctrl: assert property (p_read_ctrl) else $error("bad ctrl readback");

	property p_mode2;
		@(posedge clk) disable iff (reset) (mode == `CMX_MODE_TWO_SW && !switch_bit) |->
			(c1_inv_sel == CMX_SRC_PIN0 && c2_inv_sel == CMX_SRC_PIN1);
	endproperty
	a_mode2: assert property (p_mode2) else $error("mode 010 routing");

	property p_vref;
		@(posedge clk) disable iff (reset) (mode == `CMX_MODE_TWO_SW) |-> (c1_non_sel == CMX_SRC_VREF);
	endproperty
	a_vref: assert property (p_vref) else $error("vref not selected");

	sequence s_out_mode;
		mode == `CMX_MODE_TWO_OUT;
	endsequence
	property p_pin3;
		@(posedge clk) disable iff (reset) s_out_mode ##1 s_out_mode |-> analog_pin_three_oe;
	endproperty
	a_pin3: assert property (p_pin3) else $error("pin three not driven");

	property p_pin4;
		@(posedge clk) disable iff (reset) (mode != `CMX_MODE_TWO_OUT) ##1 (mode != `CMX_MODE_TWO_OUT) |-> !open_drain_timer_pin_oe;
	endproperty
	a_pin4: assert property (p_pin4) else $error("pin four driven");

	property p_inputs_pins;
		@(posedge clk) disable iff (reset) (mode == `CMX_MODE_ONE_SW) |-> (c1_inv_sel inside {CMX_SRC_PIN0, CMX_SRC_PIN3});
	endproperty
	a_inputs_pins: assert property (p_inputs_pins) else $error("bad mux select");

	// ==========================================
	// mode decode: every code must steer the muxes as the mode table says
	sequence s_off_mode;
		(mode == `CMX_MODE_RESET) || (mode == `CMX_MODE_OFF);
	endsequence
	sequence s_read_hit;
		rd && hit;
	endsequence

	property p_off_idle;
		@(posedge clk) disable iff (reset) s_off_mode |-> !comparators_on;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("comparators left on");

	property p_on_active;
		@(posedge clk) disable iff (reset)
			(mode != `CMX_MODE_RESET && mode != `CMX_MODE_OFF) |-> comparators_on;
	endproperty
	a_on_active: assert property (p_on_active) else $error("comparators not on");

	property p_off_sels;
		@(posedge clk) disable iff (reset) s_off_mode |->
			(c1_inv_sel == CMX_SRC_NONE && c1_non_sel == CMX_SRC_NONE &&
			c2_inv_sel == CMX_SRC_NONE && c2_non_sel == CMX_SRC_NONE);
	endproperty
	a_off_sels: assert property (p_off_sels) else $error("mux selects not parked");

	property p_one_sw_clear;
		@(posedge clk) disable iff (reset)
			(mode == `CMX_MODE_ONE_SW && !switch_bit) |-> (c1_inv_sel == CMX_SRC_PIN0);
	endproperty
	a_one_sw_clear: assert property (p_one_sw_clear) else $error("switch clear not on pin zero");

	property p_one_sw_set;
		@(posedge clk) disable iff (reset)
			(mode == `CMX_MODE_ONE_SW && switch_bit) |-> (c1_inv_sel == CMX_SRC_PIN3);
	endproperty
	a_one_sw_set: assert property (p_one_sw_set) else $error("switch set not on pin three");

	property p_one_sw_rest;
		@(posedge clk) disable iff (reset) (mode == `CMX_MODE_ONE_SW) |->
			(c1_non_sel == CMX_SRC_PIN2 && c2_inv_sel == CMX_SRC_PIN1 && c2_non_sel == CMX_SRC_PIN2);
	endproperty
	a_one_sw_rest: assert property (p_one_sw_rest) else $error("shared reference routing");

	property p_two_sw_set;
		@(posedge clk) disable iff (reset) (mode == `CMX_MODE_TWO_SW && switch_bit) |->
			(c1_inv_sel == CMX_SRC_PIN3 && c2_inv_sel == CMX_SRC_PIN2);
	endproperty
	a_two_sw_set: assert property (p_two_sw_set) else $error("switched inputs not moved");

	property p_vref_second;
		@(posedge clk) disable iff (reset) (mode == `CMX_MODE_TWO_SW) |-> (c2_non_sel == CMX_SRC_VREF);
	endproperty
	a_vref_second: assert property (p_vref_second) else $error("second vref not selected");

	property p_two_ref;
		@(posedge clk) disable iff (reset) (mode == `CMX_MODE_TWO_REF) |->
			(c1_inv_sel == CMX_SRC_PIN0 && c1_non_sel == CMX_SRC_PIN3 &&
			c2_inv_sel == CMX_SRC_PIN1 && c2_non_sel == CMX_SRC_PIN2);
	endproperty
	a_two_ref: assert property (p_two_ref) else $error("independent mode routing");

	property p_two_out_sels;
		@(posedge clk) disable iff (reset) s_out_mode |->
			(c1_inv_sel == CMX_SRC_PIN0 && c1_non_sel == CMX_SRC_PIN2 &&
			c2_inv_sel == CMX_SRC_PIN1 && c2_non_sel == CMX_SRC_PIN2);
	endproperty
	a_two_out_sels: assert property (p_two_out_sels) else $error("output mode routing");

	// codes with no special role fall back to two independent pin comparators
	property p_spare_modes;
		@(posedge clk) disable iff (reset) !(mode inside {`CMX_MODE_RESET, `CMX_MODE_ONE_SW, `CMX_MODE_TWO_SW,
			`CMX_MODE_TWO_REF, `CMX_MODE_TWO_OUT, `CMX_MODE_OFF}) |->
			(c1_inv_sel == CMX_SRC_PIN0 && c1_non_sel == CMX_SRC_PIN3 &&
			c2_inv_sel == CMX_SRC_PIN1 && c2_non_sel == CMX_SRC_PIN2);
	endproperty
	a_spare_modes: assert property (p_spare_modes) else $error("spare mode routing");

	// ==========================================
	// result and read path: one cycle to the result bits, one more to read data
	property p_result_masked;
		@(posedge clk) disable iff (reset) !comparators_on |=> (!first_result_bit && !second_result_bit);
	endproperty
	a_result_masked: assert property (p_result_masked) else $error("result bit set while off");

	property p_first_follow;
		@(posedge clk) disable iff (reset) comparators_on |=> (first_result_bit == $past(first_result_in));
	endproperty
	a_first_follow: assert property (p_first_follow) else $error("first result stale");

	property p_second_follow;
		@(posedge clk) disable iff (reset) comparators_on |=> (second_result_bit == $past(second_result_in));
	endproperty
	a_second_follow: assert property (p_second_follow) else $error("second result stale");

	property p_read_first;
		@(posedge clk) disable iff (reset) s_read_hit |=> (rdata[`CMX_FIRST_BIT] == $past(first_result_bit));
	endproperty
	a_read_first: assert property (p_read_first) else $error("first result readback");

	property p_read_second;
		@(posedge clk) disable iff (reset) s_read_hit |=> (rdata[`CMX_SECOND_BIT] == $past(second_result_bit));
	endproperty
	a_read_second: assert property (p_read_second) else $error("second result readback");

	property p_read_idle;
		@(posedge clk) disable iff (reset) !(rd && hit) |=> (rdata == 8'h00);
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data not cleared");

	property p_ctrl_hold;
		@(posedge clk) disable iff (reset) !(wr && hit) |=> $stable(ctrl);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("ctrl changed without write");

	property p_rdata_reset;
		@(posedge clk) reset |=> (rdata == 8'h00);
	endproperty
	a_rdata_reset: assert property (p_rdata_reset) else $error("read data not cleared by reset");

	// ==========================================
	// pin drivers: registered one cycle behind the result bits and the mode
	property p_pins_reset;
		@(posedge clk) reset |=> (!analog_pin_three_oe && !open_drain_timer_pin_oe);
	endproperty
	a_pins_reset: assert property (p_pins_reset) else $error("pin driven during reset");

	property p_pin3_data;
		@(posedge clk) disable iff (reset) 1'b1 |=> (analog_pin_three_out == $past(first_result_bit));
	endproperty
	a_pin3_data: assert property (p_pin3_data) else $error("pin three data stale");

	property p_pin3_release;
		@(posedge clk) disable iff (reset) (mode != `CMX_MODE_TWO_OUT) |=> !analog_pin_three_oe;
	endproperty
	a_pin3_release: assert property (p_pin3_release) else $error("pin three not released");

	property p_pin4_low;
		@(posedge clk) disable iff (reset) 1'b1 |-> !open_drain_timer_pin_out;
	endproperty
	a_pin4_low: assert property (p_pin4_low) else $error("open drain pin driven high");

	property p_pin4_drive;
		@(posedge clk) disable iff (reset)
			(mode == `CMX_MODE_TWO_OUT && !second_result_bit) |=> open_drain_timer_pin_oe;
	endproperty
	a_pin4_drive: assert property (p_pin4_drive) else $error("pin four not pulled low");

	property p_pin4_release;
		@(posedge clk) disable iff (reset) second_result_bit |=> !open_drain_timer_pin_oe;
	endproperty
	a_pin4_release: assert property (p_pin4_release) else $error("pin four held on high result");
endmodule : cmx_top

// *** rtl/cmx_params.svh ***
// constants for the comparator mux control block: offsets, fields, reset values, mode codes
// assumes a core data bus with 8-bit data; included by the package and both modules
//
// Function
// - two comparator inputs muxed from analog pins zero to three by control register
// - on-chip voltage reference selectable as a comparator input instead of pins
// - control register decoded at data address 1fh; controls input and output muxes
// - mode 010 with switch zero: c1 inverting from pin zero, c2 from pin one
// - a comparator result may drive port pin four, alternative to timer clock
// - analog pin three acts as comparator input or result output by mode
`ifndef CMX_PARAMS_SVH
`define CMX_PARAMS_SVH
// ==========================================
// register map
`define CMX_ADDR_W        7
`define CMX_CTRL_ADDR     7'h1f
`define CMX_CTRL_RESET    4'h0
`define CMX_WR_MASK       8'h0f
// ==========================================
// field positions
`define CMX_MODE_LO       0
`define CMX_MODE_HI       2
`define CMX_SWITCH_BIT    3
`define CMX_FIRST_BIT     6
`define CMX_SECOND_BIT    7
// ==========================================
// mode codes
`define CMX_MODE_RESET    3'h0
`define CMX_MODE_ONE_SW   3'h1
`define CMX_MODE_TWO_SW   3'h2
`define CMX_MODE_TWO_REF  3'h3
`define CMX_MODE_TWO_OUT  3'h6
`define CMX_MODE_OFF      3'h7
`endif

// *** rtl/cmx_pkg.sv ***
// types shared by the comparator mux control block
// assumes cmx_params.svh for all numeric constants
`include "cmx_params.svh"
package cmx_pkg;
	// ==========================================
	// analog source selection for a comparator input
	typedef enum logic [2:0] {
		CMX_SRC_NONE,
		CMX_SRC_PIN0,
		CMX_SRC_PIN1,
		CMX_SRC_PIN2,
		CMX_SRC_PIN3,
		CMX_SRC_VREF
	} cmx_src_t;
	typedef logic [2:0] cmx_mode_t;
endpackage : cmx_pkg

// *** rtl/cmx_route.sv ***
// combinational decode from mode and switch to analog mux selects and pin routing
// assumes mode and switch come straight from the control register
`include "cmx_params.svh"
module cmx_route (
	// control fields
	input  wire logic             switch_bit,
	input  wire cmx_pkg::cmx_mode_t mode,
	// mux selects
	output cmx_pkg::cmx_src_t     c1_inv_sel,
	output cmx_pkg::cmx_src_t     c1_non_sel,
	output cmx_pkg::cmx_src_t     c2_inv_sel,
	output cmx_pkg::cmx_src_t     c2_non_sel,
	// pin routing
	output logic                  pin3_is_output,
	output logic                  pin4_drives_result,
	output logic                  comparators_on
);
	import cmx_pkg::*;
	// ==========================================
	// input and output mux decode
	always_comb begin
		c1_inv_sel         = CMX_SRC_NONE;
		c1_non_sel         = CMX_SRC_NONE;
		c2_inv_sel         = CMX_SRC_NONE;
		c2_non_sel         = CMX_SRC_NONE;
		pin3_is_output     = 1'b0;
		pin4_drives_result = 1'b0;
		comparators_on     = 1'b1;
		case (mode)
			`CMX_MODE_ONE_SW: begin
				// one shared reference pin, switch picks pin three or zero
				c1_inv_sel = switch_bit ? CMX_SRC_PIN3 : CMX_SRC_PIN0;
				c1_non_sel = CMX_SRC_PIN2;
				c2_inv_sel = CMX_SRC_PIN1;
				c2_non_sel = CMX_SRC_PIN2;
			end
			`CMX_MODE_TWO_SW: begin
				// both inverting inputs switched, reference on non-inverting
				c1_inv_sel = switch_bit ? CMX_SRC_PIN3 : CMX_SRC_PIN0;
				c2_inv_sel = switch_bit ? CMX_SRC_PIN2 : CMX_SRC_PIN1;
				c1_non_sel = CMX_SRC_VREF;
				c2_non_sel = CMX_SRC_VREF;
			end
			`CMX_MODE_TWO_REF: begin
				c1_inv_sel = CMX_SRC_PIN0;
				c1_non_sel = CMX_SRC_PIN3;
				c2_inv_sel = CMX_SRC_PIN1;
				c2_non_sel = CMX_SRC_PIN2;
			end
			`CMX_MODE_TWO_OUT: begin
				// pin three gives up input role to carry result one
				c1_inv_sel         = CMX_SRC_PIN0;
				c1_non_sel         = CMX_SRC_PIN2;
				c2_inv_sel         = CMX_SRC_PIN1;
				c2_non_sel         = CMX_SRC_PIN2;
				pin3_is_output     = 1'b1;
				pin4_drives_result = 1'b1;
			end
			`CMX_MODE_RESET,
			`CMX_MODE_OFF: begin
				comparators_on = 1'b0;
			end
			default: begin
				// remaining codes: independent comparators on pins
				c1_inv_sel = CMX_SRC_PIN0;
				c1_non_sel = CMX_SRC_PIN3;
				c2_inv_sel = CMX_SRC_PIN1;
				c2_non_sel = CMX_SRC_PIN2;
			end
		endcase
	end
endmodule : cmx_route

// *** verification/cmx_analog_model.sv ***
// analog side model: pin and reference levels compared through the selected mux paths
// assumes selects come from cmx_top and the bench sets the levels between tests
module cmx_analog_model (
	// mux selects
	input  wire cmx_pkg::cmx_src_t c1_inv_sel,
	input  wire cmx_pkg::cmx_src_t c1_non_sel,
	input  wire cmx_pkg::cmx_src_t c2_inv_sel,
	input  wire cmx_pkg::cmx_src_t c2_non_sel,
	input  wire logic              comparators_on,
	// comparator levels
	output logic                   first_result,
	output logic                   second_result
);
	timeunit 1ns;
	timeprecision 1ps;
	import cmx_pkg::*;
	// index is the source code: none, pin0..pin3, reference
	// levels start mid-scale; only the bench changes them afterwards
	logic [7:0] volt [0:5] = '{default: 8'h80};
	// strict greater-than, so equal levels read low
	assign first_result  = comparators_on & (volt[c1_non_sel] > volt[c1_inv_sel]);
	assign second_result = comparators_on & (volt[c2_non_sel] > volt[c2_inv_sel]);
endmodule : cmx_analog_model

// *** verification/comparator_mux_control_tb.sv ***
// self-checking bench for cmx_top with the analog model on its far side
// assumes single 125 MHz clock; read data checked from a queue of notes
module comparator_mux_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cmx_pkg::*;
	logic clk = 0, reset = 1, wr = 0, rd = 0, rd_q = 0, f_res, s_res;
	logic [6:0] addr = 7'h00;
	logic [7:0] wdata = 8'h00, rdata, e;
	cmx_src_t c1i, c1n, c2i, c2n;
	logic on, p3o, p3e, p4o, p4e;
	int n_errors = 0, checks = 0;
	logic [7:0] exp_q [$];
	always #4 clk = ~clk;
	cmx_top u_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .first_result_in(f_res), .second_result_in(s_res), .c1_inv_sel(c1i),
		.c1_non_sel(c1n), .c2_inv_sel(c2i), .c2_non_sel(c2n), .comparators_on(on),
		.analog_pin_three_out(p3o), .analog_pin_three_oe(p3e),
		.open_drain_timer_pin_out(p4o), .open_drain_timer_pin_oe(p4e));
	cmx_analog_model u_ana (.c1_inv_sel(c1i), .c1_non_sel(c1n), .c2_inv_sel(c2i),
		.c2_non_sel(c2n), .comparators_on(on), .first_result(f_res), .second_result(s_res));
	// ==========================================
	// shared tasks
	task check(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want) begin
			n_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check
	task wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [6:0] a, input logic [7:0] want);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back(want);
		@(posedge clk);
		rd <= 1'b0;
	endtask : rd_reg
	task tally_and_finish;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	// ==========================================
	// monitor: read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_q) check(rdata, exp_q.pop_front());
		rd_q <= rd;
	end
	// watchdog well beyond the hundred or so cycles the tests need
	initial begin
		#100000;
		n_errors++;
		tally_and_finish();
	end
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(40650));
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		rd_reg(7'h1f, 8'h00);
		// every mode with equal levels: results stay low, upper writes dropped
		for (int m = 0; m < 8; m++) begin
			wr_reg(7'h1f, 8'hf0 | 8'(m));
			repeat (3) @(posedge clk);
			check(8'(on), 8'(m != 0 && m != 7));
			rd_reg(7'h1f, 8'(m));
		end
		// mode 010, switch clear, random levels; nonblocking so this edge sees the old ones
		foreach (u_ana.volt[i]) u_ana.volt[i] <= 8'($urandom);
		wr_reg(7'h1f, 8'h02);
		repeat (3) @(posedge clk);
		check(8'(c1i), 8'(CMX_SRC_PIN0));
		check(8'(c2i), 8'(CMX_SRC_PIN1));
		check(8'(c1n), 8'(CMX_SRC_VREF));
		check(8'(c2n), 8'(CMX_SRC_VREF));
		e = {u_ana.volt[5] > u_ana.volt[2], u_ana.volt[5] > u_ana.volt[1], 6'h02};
		rd_reg(7'h1f, e);
		rd_reg(7'h1e, 8'h00);
		// switch set moves the inverting inputs to pins three and two
		wr_reg(7'h1f, 8'h0a);
		@(posedge clk);
		check(8'(c1i), 8'(CMX_SRC_PIN3));
		check(8'(c2i), 8'(CMX_SRC_PIN2));
		// shared reference mode with the switch set
		wr_reg(7'h1f, 8'h09);
		@(posedge clk);
		check(8'(c1i), 8'(CMX_SRC_PIN3));
		check(8'(c1n), 8'(CMX_SRC_PIN2));
		// result outputs on pins three and four; both compare against pin two
		wr_reg(7'h1f, 8'h06);
		repeat (3) @(posedge clk);
		check(8'(p3e), 8'h01);
		check(8'(p3o), 8'(u_ana.volt[3] > u_ana.volt[1]));
		check(8'(p4o), 8'h00);
		check(8'(p4e), 8'(!(u_ana.volt[3] > u_ana.volt[2])));
		wr_reg(7'h1f, 8'h02);
		repeat (3) @(posedge clk);
		check(8'(p3e | p4e), 8'h00);
		// reset in mid-run clears the control bits and masks the results
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		check(8'(on), 8'h00);
		rd_reg(7'h1f, 8'h00);
		repeat (2) @(posedge clk);
		tally_and_finish();
	end
endmodule : comparator_mux_control_tb
